// ==== include/mcu_decode_pkg.sv ====
// Shared types and constants for the instruction decode and execute core
package mcu_decode_pkg;

  // Instruction word layout
  localparam int WORD_W     = 14;
  localparam int PC_W       = 13;
  localparam int STACK_N    = 8;
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT  = 2'h1;
  localparam logic [1:0] CLS_CTRL = 2'h2;
  localparam logic [1:0] CLS_LIT  = 2'h3;

  // Byte-class operation codes, word bits 11:8
  localparam logic [3:0] OP_MISC  = 4'h0;
  localparam logic [3:0] OP_CLR   = 4'h1;
  localparam logic [3:0] OP_SUB   = 4'h2;
  localparam logic [3:0] OP_DEC   = 4'h3;
  localparam logic [3:0] OP_IOR   = 4'h4;
  localparam logic [3:0] OP_AND   = 4'h5;
  localparam logic [3:0] OP_XOR   = 4'h6;
  localparam logic [3:0] OP_ADD   = 4'h7;
  localparam logic [3:0] OP_MOVE_FILE  = 4'h8;
  localparam logic [3:0] OP_COM   = 4'h9;
  localparam logic [3:0] OP_INC   = 4'hA;
  localparam logic [3:0] OP_DECSZ = 4'hB;
  localparam logic [3:0] OP_RRC   = 4'hC;
  localparam logic [3:0] OP_RLC   = 4'hD;
  localparam logic [3:0] OP_SWAP  = 4'hE;
  localparam logic [3:0] OP_INCSZ = 4'hF;

  // Misc group, word bits 6:0 with bit 7 clear
  localparam logic [6:0] MISC_RET   = 7'h08;
  localparam logic [6:0] MISC_RETIE = 7'h09;
  localparam logic [6:0] MISC_SLEEP = 7'h63;
  localparam logic [6:0] MISC_WDCLR = 7'h64;

  // Special file addresses
  localparam logic [6:0] TIMER_ZERO_ADDR = 7'h01;

  // Register map, byte addresses
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_PAGE  = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_PRE_BIT = 1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {S_HALT, S_DECODE, S_EXECUTE, S_SLEEP} state_t;
  typedef enum logic [1:0] {FL_NONE, FL_SKIP, FL_HOLD} flush_t;

  // Data register file request group
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wrData;
    logic       rdStrobe;
    logic       wrStrobe;
    logic       pinRead;
  } file_req_t;

  typedef struct packed {
    state_t st; flush_t flush; logic dummy;
    logic [WORD_W-1:0] instr; logic [PC_W-1:0] pc; logic [7:0] acc;
    logic carry, digit, zero, tof, pdf, global_irq_enable;
    logic [2:0] sp; logic [STACK_N-1:0][PC_W-1:0] stack;
    file_req_t file;
    logic wdClr, slp, preClr, runEn, preAssign; logic [4:0] page;
    logic awFull, wFull, awReady, wReady, bValid, arReady, rValid;
    logic [7:0] awAddr; logic [31:0] wData; logic [3:0] wStrb;
    logic [1:0] bResp, rResp; logic [31:0] rData;
  } core_state_t;

  localparam core_state_t CORE_RESET = '{st: S_HALT, flush: FL_NONE,
    tof: 1'b1, pdf: 1'b1, awReady: 1'b1, wReady: 1'b1, arReady: 1'b1,
    default: '0};

endpackage

// ==== logic/mcu_decode_core.sv ====
// Instruction decode and execute core with register access slave
// Behaviour
// - File operands are always read first, then modified and stored.
// - Destination bit clear sends result to accumulator, set to file.
// - File address is the low seven bits, range 00 to 7F.
// - Add and subtract accumulator with file update carry, digit, zero.
// - AND, OR, XOR, complement, inc, dec, move-file change zero only.
// - Inc/dec-skip write result; zero result skips next word; no flags.
// - Rotates go through carry, touching carry only; swap changes none.
// - Don't-care bits ignored; clear-acc and no-op decoded loosely.
// - Clear-file writes zero, clear-acc zeroes acc; both set zero.
// - Store-acc copies accumulator to file, flags untouched.
// - Bit class clears or sets one selected bit without flags.
// - Bit tests skip next word on clear or set, costing a cycle.
// - Literal OR and XOR write accumulator and change zero only.
// - Add and subtract literal set three flags; AND literal zero only.
// - Call pushes next address, loads 11-bit target plus page bits.
// - Branch loads 11-bit target plus page bits, two cycles.
// - Returns pop; literal return loads acc; interrupt return sets enable.
// - Watchdog clear pulses reset and sets timeout and power-down flags.
// - Standby takes one cycle and updates timeout and power-down flags.
// - Program counter change or true test costs a dummy second cycle.
// - Writing timer zero count clears its prescaler when assigned.
// - Self-modifying reads of port registers take pin levels.
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module mcu_decode_core (
  // Clock and reset
  input  wire logic                              ref_clk,
  input  wire logic                              reset_n,
  // Register access slave
  input  wire logic [7:0]                        awaddr,
  input  wire logic                              awvalid,
  output      logic                              awready,
  input  wire logic [31:0]                       wdata,
  input  wire logic [3:0]                        wstrb,
  input  wire logic                              wvalid,
  output      logic                              wready,
  output      logic [1:0]                        bresp,
  output      logic                              bvalid,
  input  wire logic                              bready,
  input  wire logic [7:0]                        araddr,
  input  wire logic                              arvalid,
  output      logic                              arready,
  output      logic [31:0]                       rdata,
  output      logic [1:0]                        rresp,
  output      logic                              rvalid,
  input  wire logic                              rready,
  // Program memory
  output      logic [mcu_decode_pkg::PC_W-1:0]   progAddr,
  input  wire logic [mcu_decode_pkg::WORD_W-1:0] instrWord,
  // Data register file
  output      mcu_decode_pkg::file_req_t         fileReq,
  input  wire logic [7:0]                        fileRdData,
  // Side controls
  input  wire logic                              wakeEvent,
  output      logic                              watchdogClear,
  output      logic                              sleepEntered,
  output      logic                              timerPrescalerClear,
  output      logic                              globalIrqEnable
);
  import mcu_decode_pkg::*;

  core_state_t q;
  core_state_t n;

  // Adder giving {carry, digit carry, sum}; subtract passes ~b with cin set
  function automatic logic [9:0] add8(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic       cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    return {full[8], lo[4], full[7:0]};
  endfunction

  // Next-state logic: bus slave first, then the instruction sequencer
  always_comb begin
    logic [7:0]      res;
    logic [9:0]      alu;
    logic            toDest;
    logic            bitVal;
    logic [PC_W-1:0] pcInc;
    logic [2:0]      spDown;
    res    = 8'h00;
    alu    = 10'h000;
    toDest = 1'b0;
    bitVal = 1'b0;
    pcInc  = q.pc + 13'h0001;
    spDown = q.sp - 3'h1;
    n = q;
    n.file.rdStrobe = 1'b0;
    n.file.wrStrobe = 1'b0;
    n.file.pinRead  = 1'b0;
    n.wdClr  = 1'b0;
    n.slp    = 1'b0;
    n.preClr = 1'b0;

    // Write channels are taken in either order and held until both are in
    if (awvalid && q.awReady) begin
      n.awFull = 1'b1;
      n.awAddr = awaddr;
    end
    if (wvalid && q.wReady) begin
      n.wFull = 1'b1;
      n.wData = wdata;
      n.wStrb = wstrb;
    end
    if (bready && q.bValid) begin
      n.bValid = 1'b0;
    end
    if (q.awFull && q.wFull && !q.bValid) begin
      n.awFull = 1'b0;
      n.wFull  = 1'b0;
      n.bValid = 1'b1;
      n.bResp  = RESP_OKAY;
      unique case (q.awAddr)
        ADDR_CTRL: begin
          if (q.wStrb[0]) begin
            n.runEn     = q.wData[CTRL_RUN_BIT];
            n.preAssign = q.wData[CTRL_PRE_BIT];
          end
        end
        ADDR_PAGE: begin
          if (q.wStrb[0]) n.page = q.wData[4:0];
        end
        ADDR_STATE: ;
        default: n.bResp = RESP_SLVERR;
      endcase
    end
    n.awReady = !n.awFull;
    n.wReady  = !n.wFull;

    // Read channel; one read in flight at a time
    if (rready && q.rValid) begin
      n.rValid  = 1'b0;
      n.arReady = 1'b1;
    end
    if (arvalid && q.arReady) begin
      n.arReady = 1'b0;
      n.rValid  = 1'b1;
      n.rResp   = RESP_OKAY;
      unique case (araddr)
        ADDR_CTRL:  n.rData = {30'h0, q.preAssign, q.runEn};
        ADDR_PAGE:  n.rData = {27'h0, q.page};
        ADDR_STATE: n.rData = {3'h0, q.pc, 2'h0, q.global_irq_enable, q.pdf, q.tof,
                               q.zero, q.digit, q.carry, q.acc};
        default: begin
          n.rData = 32'h0;
          n.rResp = RESP_SLVERR;
        end
      endcase
    end

    // Instruction sequencer: decode phase reads, execute phase writes
    unique case (q.st)
      S_HALT: begin
        if (q.runEn) n.st = S_DECODE;
      end
      S_SLEEP: begin
        if (wakeEvent) n.st = S_DECODE;
      end
      S_DECODE: begin
        n.st = S_EXECUTE;
        n.dummy = (q.flush != FL_NONE);
        n.flush = FL_NONE;
        if (q.flush != FL_NONE) begin
          n.instr = 14'h0000;
          if (q.flush == FL_SKIP) n.pc = pcInc;
        end else begin
          n.instr     = instrWord;
          n.file.addr = instrWord[6:0];
          // Every file-naming word reads its operand first
          if (instrWord[13] == 1'b0 &&
              !(instrWord[13:8] == 6'h00 && !instrWord[7]) &&
              !(instrWord[13:8] == 6'h01 && !instrWord[7])) begin
            n.file.rdStrobe = 1'b1;
            n.file.pinRead  = 1'b1;
          end
        end
      end
      S_EXECUTE: begin
        n.st = q.runEn ? S_DECODE : S_HALT;
        if (!q.dummy) begin
          n.pc = pcInc;
          unique case (q.instr[13:12])
            CLS_BYTE: begin
              unique case (q.instr[11:8])
                OP_MISC: begin
                  if (q.instr[7]) begin
                    n.file.wrStrobe = 1'b1;
                    n.file.wrData   = q.acc;
                  end else if (q.instr[6:0] == MISC_RET ||
                               q.instr[6:0] == MISC_RETIE) begin
                    n.pc    = q.stack[spDown];
                    n.sp    = spDown;
                    n.flush = FL_HOLD;
                    if (q.instr[0]) n.global_irq_enable = 1'b1;
                  end else if (q.instr[6:0] == MISC_SLEEP) begin
                    n.tof = 1'b1;
                    n.pdf = 1'b0;
                    n.slp = 1'b1;
                    n.st  = S_SLEEP;
                  end else if (q.instr[6:0] == MISC_WDCLR) begin
                    n.wdClr = 1'b1;
                    n.tof   = 1'b1;
                    n.pdf   = 1'b1;
                  end
                  // Anything else here, no-op included, does nothing
                end
                OP_CLR: begin
                  n.zero = 1'b1;
                  if (q.instr[7]) begin
                    n.file.wrStrobe = 1'b1;
                    n.file.wrData   = 8'h00;
                  end else begin
                    n.acc = 8'h00;
                  end
                end
                OP_SUB, OP_ADD: begin
                  alu = (q.instr[11:8] == OP_ADD) ?
                        add8(fileRdData, q.acc, 1'b0) :
                        add8(fileRdData, ~q.acc, 1'b1);
                  res     = alu[7:0];
                  n.carry = alu[9];
                  n.digit = alu[8];
                  n.zero  = (res == 8'h00);
                  toDest  = 1'b1;
                end
                OP_DEC, OP_IOR, OP_AND, OP_XOR, OP_MOVE_FILE, OP_COM, OP_INC:
                begin
                  unique case (q.instr[11:8])
                    OP_DEC:  res = fileRdData - 8'h01;
                    OP_IOR:  res = fileRdData | q.acc;
                    OP_AND:  res = fileRdData & q.acc;
                    OP_XOR:  res = fileRdData ^ q.acc;
                    OP_MOVE_FILE: res = fileRdData;
                    OP_COM:  res = ~fileRdData;
                    default: res = fileRdData + 8'h01;
                  endcase
                  n.zero = (res == 8'h00);
                  toDest = 1'b1;
                end
                OP_DECSZ, OP_INCSZ: begin
                  res = (q.instr[11:8] == OP_INCSZ) ?
                        fileRdData + 8'h01 : fileRdData - 8'h01;
                  toDest = 1'b1;
                  if (res == 8'h00) n.flush = FL_SKIP;
                end
                OP_RRC: begin
                  res     = {q.carry, fileRdData[7:1]};
                  n.carry = fileRdData[0];
                  toDest  = 1'b1;
                end
                OP_RLC: begin
                  res     = {fileRdData[6:0], q.carry};
                  n.carry = fileRdData[7];
                  toDest  = 1'b1;
                end
                OP_SWAP: begin
                  res    = {fileRdData[3:0], fileRdData[7:4]};
                  toDest = 1'b1;
                end
              endcase
            end
            CLS_BIT: begin
              bitVal = fileRdData[q.instr[9:7]];
              res    = fileRdData;
              res[q.instr[9:7]] = q.instr[10];
              if (!q.instr[11]) begin
                n.file.wrStrobe = 1'b1;
                n.file.wrData   = res;
              end else if (bitVal == q.instr[10]) begin
                n.flush = FL_SKIP;
              end
            end
            CLS_CTRL: begin
              if (!q.instr[11]) begin
                n.stack[q.sp] = pcInc;
                n.sp          = q.sp + 3'h1;
              end
              n.pc    = {q.page[4:3], q.instr[10:0]};
              n.flush = FL_HOLD;
            end
            CLS_LIT: begin
              unique case (q.instr[11:10])
                2'h0: n.acc = q.instr[7:0];
                2'h1: begin
                  n.acc   = q.instr[7:0];
                  n.pc    = q.stack[spDown];
                  n.sp    = spDown;
                  n.flush = FL_HOLD;
                end
                2'h2: begin
                  unique case (q.instr[9:8])
                    2'h0: res = q.acc | q.instr[7:0];
                    2'h1: res = q.acc & q.instr[7:0];
                    2'h2: res = q.acc ^ q.instr[7:0];
                    default: res = q.acc;
                  endcase
                  if (q.instr[9:8] != 2'h3) begin
                    n.acc  = res;
                    n.zero = (res == 8'h00);
                  end
                end
                2'h3: begin
                  alu = q.instr[9] ? add8(q.instr[7:0], q.acc, 1'b0) :
                        add8(q.instr[7:0], ~q.acc, 1'b1);
                  n.acc   = alu[7:0];
                  n.carry = alu[9];
                  n.digit = alu[8];
                  n.zero  = (alu[7:0] == 8'h00);
                end
              endcase
            end
          endcase
          // Result routing by destination select
          if (toDest) begin
            if (q.instr[7]) begin
              n.file.wrStrobe = 1'b1;
              n.file.wrData   = res;
            end else begin
              n.acc = res;
            end
          end
          // Timer zero writes also reset its prescaler when it owns it
          if (n.file.wrStrobe && q.file.addr == TIMER_ZERO_ADDR &&
              q.preAssign) begin
            n.preClr = 1'b1;
          end
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= CORE_RESET;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from the state register
  assign awready             = q.awReady;
  assign wready              = q.wReady;
  assign bvalid              = q.bValid;
  assign bresp               = q.bResp;
  assign arready             = q.arReady;
  assign rvalid              = q.rValid;
  assign rdata               = q.rData;
  assign rresp               = q.rResp;
  assign progAddr            = q.pc;
  assign fileReq             = q.file;
  assign watchdogClear       = q.wdClr;
  assign sleepEntered        = q.slp;
  assign timerPrescalerClear = q.preClr;
  assign globalIrqEnable     = q.global_irq_enable;

  // Checks on the sequencer
  logic execNow;
  assign execNow = (q.st == S_EXECUTE) && !q.dummy;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence seq_dummy_slot;
    ##1 (q.st == S_DECODE) ##1 (q.st == S_EXECUTE && q.dummy);
  endsequence

  a_operand_read: assert property (
    execNow && q.instr[13:12] == CLS_BYTE && q.instr[11:8] == OP_ADD
    |-> q.file.rdStrobe)
    else $error("operand not read before add");
  a_dest_select: assert property (
    execNow && q.instr[13:12] == CLS_BYTE && q.instr[11:8] == OP_ADD
    |=> (q.file.wrStrobe == $past(q.instr[7])))
    else $error("add result sent to wrong destination");
  a_branch_target: assert property (
    execNow && q.instr[13:11] == 3'h5 && q.runEn
    |-> seq_dummy_slot and
        (##1 (q.pc == {$past(q.page[4:3]), $past(q.instr[10:0])})))
    else $error("branch target or dummy cycle wrong");
  a_call_push: assert property (
    execNow && q.instr[13:11] == 3'h4
    |=> q.sp == $past(q.sp) + 3'h1 &&
        q.stack[$past(q.sp)] == $past(q.pc) + 13'h0001)
    else $error("call did not push return address");
  a_skip_zero: assert property (
    execNow && q.instr[13:8] == 6'h0B && fileRdData == 8'h01 && q.runEn
    |-> seq_dummy_slot)
    else $error("zero result did not skip");
  a_clear_acc: assert property (
    execNow && q.instr[13:8] == 6'h01 && !q.instr[7]
    |=> q.acc == 8'h00 && q.zero && !q.file.wrStrobe)
    else $error("clear accumulator failed");
  a_wdog_flags: assert property (
    execNow && q.instr[13:7] == 7'h00 && q.instr[6:0] == MISC_WDCLR
    |=> watchdogClear && q.tof && q.pdf ##1 !watchdogClear)
    else $error("watchdog clear pulse or flags wrong");
  a_swap_flags: assert property (
    execNow && q.instr[13:8] == 6'h0E
    |=> $stable({q.carry, q.digit, q.zero}))
    else $error("swap changed a flag");
  a_timer_clear: assert property (
    q.file.wrStrobe && q.file.addr == TIMER_ZERO_ADDR && q.preAssign
    && $past(execNow) |-> timerPrescalerClear)
    else $error("timer prescaler not cleared");
  a_irq_return: assert property (
    execNow && q.instr == 14'h0009 |=> globalIrqEnable && q.flush == FL_HOLD)
    else $error("interrupt return did not enable");

endmodule

// ==== verif/mcu_mem_model.sv ====
// Program memory and data register file facing the decode core
`timescale 1ns/1ps
module mcu_mem_model (
  // Clock
  input  wire logic                              ref_clk,
  // Fetch port
  input  wire logic [mcu_decode_pkg::PC_W-1:0]   progAddr,
  output      logic [mcu_decode_pkg::WORD_W-1:0] instrWord,
  // Operand port
  input  wire mcu_decode_pkg::file_req_t         fileReq,
  output      logic [7:0]                        fileRdData
);
  import mcu_decode_pkg::*;
  logic [WORD_W-1:0] rom [32];
  logic [7:0]        ram [128];
  // Start from a known file so stray reads never look like fresh data
  initial begin
    foreach (ram[i]) ram[i] = 8'h00;
  end
  // Words past the table fetch as zero, which is a plain no-op
  assign instrWord  = (progAddr < 13'h0020) ? rom[progAddr[4:0]] : '0;
  assign fileRdData = ram[fileReq.addr];
  // Store only at the edge where the strobe is high
  always @(posedge ref_clk) begin
    if (fileReq.wrStrobe === 1'b1) begin
      ram[fileReq.addr] <= fileReq.wrData;
    end
  end
endmodule

// ==== verif/mcu_instruction_decode_execute_tb.sv ====
// Self-checking bench: register bus access and a short program run
`timescale 1ns/1ps
`define CHK(a, e) begin cmpCount++; if ((a) !== (e)) begin failCount++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module mcu_instruction_decode_execute_tb;
  import mcu_decode_pkg::*;
  logic ref_clk = 0, reset_n = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, wakeEvent = 1;
  logic awready, wready, bvalid, arready, rvalid, watchdogClear;
  logic sleepEntered, timerPrescalerClear, globalIrqEnable;
  logic [7:0] awaddr = '0, araddr = '0, fileRdData;
  logic [31:0] wdata = '0, rdata, rd;
  logic [3:0] wstrb = '0;
  logic [1:0] bresp, rresp, rsp;
  logic [PC_W-1:0] progAddr;
  logic [WORD_W-1:0] instrWord;
  file_req_t fileReq;
  int failCount = 0, cmpCount = 0, wdN = 0, psN = 0, slN = 0, n;
  mcu_decode_core uut (.ref_clk(ref_clk), .reset_n(reset_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .progAddr(progAddr), .instrWord(instrWord),
    .fileReq(fileReq), .fileRdData(fileRdData), .wakeEvent(wakeEvent),
    .watchdogClear(watchdogClear), .sleepEntered(sleepEntered),
    .timerPrescalerClear(timerPrescalerClear),
    .globalIrqEnable(globalIrqEnable));
  mcu_mem_model mem (.ref_clk(ref_clk), .progAddr(progAddr),
    .instrWord(instrWord), .fileReq(fileReq), .fileRdData(fileRdData));
  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;
  // Count one-cycle side pulses, sampled before the edge updates land
  always @(posedge ref_clk) begin
    if (watchdogClear === 1'b1) wdN++;
    if (timerPrescalerClear === 1'b1) psN++;
    if (sleepEntered === 1'b1) slN++;
  end
  // Bus write: both channels offered together, each dropped when taken
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    awaddr <= a; wdata <= d; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    @(posedge ref_clk);
    while (awvalid || wvalid || bready) begin
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        bready <= 1'b0;
        rsp = bresp;
      end
      @(posedge ref_clk);
    end
  endtask
  // Bus read: address held until taken, data taken at the rvalid edge
  task automatic axiRd(input logic [7:0] a);
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    @(posedge ref_clk);
    while (arvalid || rready) begin
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        rready <= 1'b0;
        rd = rdata;
        rsp = rresp;
      end
      @(posedge ref_clk);
    end
  endtask
  task automatic stopTest;
    $display("Counts: %0d compares, %0d mismatches", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Whole run is well under this span; a hang ends here
  initial begin
    #(50 * 20000);
    failCount++;
    stopTest();
  end
  initial begin
    // Skips land on the 0xEE load and the 0x20 clear-file, so file 0x01 and acc tell if they were dropped
    mem.rom = '{14'h300F, 14'h3E01, 14'h00A0, 14'h0AA0, 14'h1C20,
      14'h30EE, 14'h2808, 14'h3055, 14'h01A1, 14'h0081, 14'h200D,
      14'h0064, 14'h2810, 14'h343C, 14'h0000, 14'h0000,
      // Skip over a clear-file, swap into acc, call a return-from-irq
      14'h0AA1, 14'h0BA1, 14'h01A0, 14'h0E20, 14'h2018, 14'h0063,
      14'h2816, 14'h0000, 14'h0009, 14'h0000, 14'h0000, 14'h0000,
      14'h0000, 14'h0000, 14'h0000, 14'h0000};
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    axiRd(ADDR_STATE);
    `CHK(rd, 32'h00001800)
    axiRd(ADDR_CTRL);
    `CHK(rd, 32'h00000000)
    axiRd(8'h0C);
    `CHK(rsp, RESP_SLVERR)
    axiWr(8'h0C, 32'h0000_0001);
    `CHK(rsp, RESP_SLVERR)
    $display("Test register access done");
    axiWr(ADDR_CTRL, 32'h0000_0003);
    `CHK(rsp, RESP_OKAY)
    for (n = 0; n < 2000 && slN == 0; n++) @(posedge ref_clk);
    repeat (20) @(posedge ref_clk);
    axiWr(ADDR_CTRL, 32'h0000_0000);
    repeat (10) @(posedge ref_clk);
    axiRd(ADDR_STATE);
    `CHK(rd[15:0], 16'h2A11)
    `CHK(rd[28:16], 13'h0016)
    `CHK(globalIrqEnable, 1'b1)
    `CHK(slN, 1)
    `CHK(mem.ram[7'h20], 8'h11)
    `CHK(mem.ram[7'h21], 8'h00)
    `CHK(mem.ram[7'h01], 8'h10)
    `CHK(psN, 1)
    `CHK(wdN, 1)
    $display("Test program run done");
    stopTest();
  end
endmodule
